//--- include/servo_sel_defines.svh
// Offsets, field positions, reset values and timing counts of the selection block
`ifndef SERVO_SEL_DEFINES_SVH
`define SERVO_SEL_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_FWD_INT 8'h04
`define OFS_REV_INT 8'h08
`define OFS_FWD_EXT 8'h0c
`define OFS_REV_EXT 8'h10
`define OFS_MOTOR_MAX 8'h14
`define OFS_DECEL 8'h18
`define OFS_STATUS 8'h1c
`define OFS_APPLIED 8'h20
`define OFS_SPEED_BASE 8'h40

// Control register fields
`define CTRL_COMBO_LSB 0
`define CTRL_COMBO_MSB 3
`define CTRL_ANA_BIT 4
`define CTRL_RESTART_BIT 8

// Applied limit register fields
`define APPLIED_REV_LSB 16

// Reset values and ranges; torque limits in percent of rated torque
`define RST_COMBO 4'h5
`define RST_ANA_EN 1'b0
`define RST_INT_LIM 10'h12c
`define RST_EXT_LIM 10'h064
`define RST_MOTOR_MAX 10'h12c
`define MAX_INT_LIM 10'h15e
`define MAX_EXT_LIM 10'h190
`define RST_DECEL_MS 16'h0064
`define RST_SPEED 16'h0000

// Timing
`define SEL_MS_NS 1000000
`define SEL_CLK_NS 10
`define SEL_MS_CYCLES (`SEL_MS_NS / `SEL_CLK_NS)

`endif

//--- include/servo_sel_pkg.sv
// Types shared by the mode and torque limit selection block
package servo_sel_pkg;

    typedef enum logic [2:0] {
        MD_SPEED_CONTACT = 3'h0,
        MD_SPEED_ANALOG = 3'h1,
        MD_POSITION = 3'h2,
        MD_TORQUE = 3'h3,
        MD_ZERO_CLAMP = 3'h4,
        MD_POS_INHIBIT = 3'h5,
        MD_DECEL = 3'h6
    } mode_t;

    typedef enum logic [2:0] {
        ST_SPEED = 3'b001,
        ST_DECEL = 3'b010,
        ST_POS = 3'b100
    } sw_state_t;

endpackage

//--- design/limit_clamp.sv
// Combines one direction's torque limit with the analog limit and motor maximum
`timescale 1ns/100ps
module limit_clamp (
    // Limit sources
    input wire logic [9:0] base_lim,
    input wire logic [9:0] ana_lim,
    input wire logic ana_use,
    input wire logic [9:0] motor_max,
    // Result
    output logic [9:0] lim_out
);

    always_comb begin
        lim_out = base_lim;
        if (ana_use && (ana_lim < lim_out)) begin
            lim_out = ana_lim;
        end
        if (lim_out > motor_max) begin
            lim_out = motor_max;
        end
    end

endmodule

//--- design/servo_mode_torque_limit_select.sv
// Control mode, internal speed and torque limit selection with an AHB-Lite slave
//
// What this block does
// - Combinations 4 to 6 pick mode and speed from switch and both selects.
// - Contact speed: switch off runs forward speeds 1-3, on reverse speeds 4-7.
// - Select inputs may be seen up to 2 ms late; logic tolerates it.
// - Contact speed to pulse position waits for stop within decel time.
// - Combinations 7, 8, 9: switch picks speed/position, torque/position, speed/torque.
// - Combination A: zero clamp or speed; B: inhibited or plain position.
// - Any limit above motor maximum torque is clamped to that maximum.
// - Forward and reverse torque are limited by their internal settings.
// - All torque limits are percentages of rated torque.
// - Forward select on applies forward external limit, off the internal one.
// - Reverse select on applies reverse external limit, off the internal one.
// - External limits accept 0 to 400 percent, reset to 100.
// - Analog limit enable makes analog reference a limit, after restart only.
// - Analog limiting acts in speed or position control, never torque.
// - Analog limit uses absolute value, applied in both directions.
// - Combination 5 pairs contact speed with position; 4 analog speed, 6 torque.
// - Torque limited flag is set while output torque is being limited.
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`include "servo_sel_defines.svh"

module servo_mode_torque_limit_select
    import servo_sel_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `SEL_MS_CYCLES
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Selection inputs from the host controller
    input wire logic MODE_SWITCH_INPUT,
    input wire logic FWD_LIMIT_SELECT_INPUT,
    input wire logic REV_LIMIT_SELECT_INPUT,
    // Drive side inputs
    input wire logic [15:0] ANALOG_TORQUE_REF_INPUT,
    input wire logic [15:0] TORQUE_DEMAND_INPUT,
    input wire logic MOTOR_STOPPED_INPUT,
    // Selection results
    output logic [2:0] ACTIVE_MODE,
    output logic [2:0] SPEED_INDEX,
    output logic DIR_REVERSE,
    output logic [15:0] SPEED_REF,
    output logic [9:0] FWD_TORQUE_LIMIT,
    output logic [9:0] REV_TORQUE_LIMIT,
    output logic TORQUE_LIMITED_FLAG
);

    // Saturates a written limit to its range
    function automatic logic [9:0] sat_lim(input logic [31:0] v, input logic [9:0] mx);
        sat_lim = (v > {22'h0, mx}) ? mx : v[9:0];
    endfunction

    // Combinations that use contact speed selection
    function automatic logic contact_combo(input logic [3:0] c);
        contact_combo = (c == 4'h4) || (c == 4'h5) || (c == 4'h6);
    endfunction

    logic mode_sw_reg;
    logic fwd_sel_reg;
    logic rev_sel_reg;
    logic [15:0] aref_reg;
    logic [15:0] tdem_reg;
    logic [3:0] combo_pend_reg;
    logic ana_en_pend_reg;
    logic [3:0] combo_act_reg;
    logic ana_en_act_reg;
    logic restart_reg;
    logic [9:0] fwd_int_reg;
    logic [9:0] rev_int_reg;
    logic [9:0] fwd_ext_reg;
    logic [9:0] rev_ext_reg;
    logic [9:0] motor_max_reg;
    logic [15:0] decel_time_reg;
    logic [15:0] speed_reg [0:7];
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic bus_acc;
    logic [31:0] rd_next;
    sw_state_t state_reg;
    sw_state_t state_next;
    logic [16:0] ms_cnt_reg;
    logic [15:0] decel_ms_reg;
    logic decel_done;
    logic [2:0] idx;
    mode_t mode_raw;
    mode_t mode_eff;
    logic goal_pos;
    logic [15:0] aref_abs;
    logic [9:0] ana_lim;
    logic ana_use;
    logic [9:0] base_lim [0:1];
    logic [9:0] lim_next [0:1];
    logic [16:0] tdem_mag;
    logic tlim_next;

    // Selection inputs are registered once; far below the allowed latency
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_sw_reg <= 1'b0;
            fwd_sel_reg <= 1'b0;
            rev_sel_reg <= 1'b0;
        end else begin
            mode_sw_reg <= MODE_SWITCH_INPUT;
            fwd_sel_reg <= FWD_LIMIT_SELECT_INPUT;
            rev_sel_reg <= REV_LIMIT_SELECT_INPUT;
        end
    end

    // Analog reference and torque demand capture
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aref_reg <= 16'h0000;
            tdem_reg <= 16'h0000;
        end else begin
            aref_reg <= ANALOG_TORQUE_REF_INPUT;
            tdem_reg <= TORQUE_DEMAND_INPUT;
        end
    end

    // Bus address phase
    assign bus_acc = HSEL && HTRANS[1] && HREADY;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= bus_acc && HWRITE;
            if (bus_acc) begin
                wr_addr_reg <= HADDR[7:0];
            end
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // Pending mode settings and restart strobe
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            combo_pend_reg <= `RST_COMBO;
            ana_en_pend_reg <= `RST_ANA_EN;
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= 1'b0;
            if (wr_pend_reg && (wr_addr_reg == `OFS_CTRL)) begin
                combo_pend_reg <= HWDATA[`CTRL_COMBO_MSB:`CTRL_COMBO_LSB];
                ana_en_pend_reg <= HWDATA[`CTRL_ANA_BIT];
                restart_reg <= HWDATA[`CTRL_RESTART_BIT];
            end
        end
    end

    // Active settings change only on restart
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            combo_act_reg <= `RST_COMBO;
            ana_en_act_reg <= `RST_ANA_EN;
        end else if (restart_reg) begin
            combo_act_reg <= combo_pend_reg;
            ana_en_act_reg <= ana_en_pend_reg;
        end
    end

    // Internal limits, percent of rated torque
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fwd_int_reg <= `RST_INT_LIM;
            rev_int_reg <= `RST_INT_LIM;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == `OFS_FWD_INT) begin
                fwd_int_reg <= sat_lim(HWDATA, `MAX_INT_LIM);
            end
            if (wr_addr_reg == `OFS_REV_INT) begin
                rev_int_reg <= sat_lim(HWDATA, `MAX_INT_LIM);
            end
        end
    end

    // External limits
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fwd_ext_reg <= `RST_EXT_LIM;
            rev_ext_reg <= `RST_EXT_LIM;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == `OFS_FWD_EXT) begin
                fwd_ext_reg <= sat_lim(HWDATA, `MAX_EXT_LIM);
            end
            if (wr_addr_reg == `OFS_REV_EXT) begin
                rev_ext_reg <= sat_lim(HWDATA, `MAX_EXT_LIM);
            end
        end
    end

    // Motor maximum torque and switch deceleration time
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            motor_max_reg <= `RST_MOTOR_MAX;
            decel_time_reg <= `RST_DECEL_MS;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == `OFS_MOTOR_MAX) begin
                motor_max_reg <= HWDATA[9:0];
            end
            if (wr_addr_reg == `OFS_DECEL) begin
                decel_time_reg <= HWDATA[15:0];
            end
        end
    end

    // Internal speeds 1 to 7; entry 0 stays zero
    for (genvar g = 0; g < 8; g++) begin : g_speed
        always_ff @(posedge CORE_CLK or negedge RST_N) begin
            if (!RST_N) begin
                speed_reg[g] <= `RST_SPEED;
            end else if (wr_pend_reg && (g != 0)
                    && (wr_addr_reg == (`OFS_SPEED_BASE + 8'(4 * g)))) begin
                speed_reg[g] <= HWDATA[15:0];
            end
        end
    end

    // Read data mux
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (HADDR[7:0])
            `OFS_CTRL: begin
                rd_next[`CTRL_COMBO_MSB:`CTRL_COMBO_LSB] = combo_pend_reg;
                rd_next[`CTRL_ANA_BIT] = ana_en_pend_reg;
            end
            `OFS_FWD_INT: rd_next[9:0] = fwd_int_reg;
            `OFS_REV_INT: rd_next[9:0] = rev_int_reg;
            `OFS_FWD_EXT: rd_next[9:0] = fwd_ext_reg;
            `OFS_REV_EXT: rd_next[9:0] = rev_ext_reg;
            `OFS_MOTOR_MAX: rd_next[9:0] = motor_max_reg;
            `OFS_DECEL: rd_next[15:0] = decel_time_reg;
            `OFS_STATUS: begin
                rd_next[2:0] = ACTIVE_MODE;
                rd_next[6:4] = SPEED_INDEX;
                rd_next[7] = DIR_REVERSE;
                rd_next[8] = TORQUE_LIMITED_FLAG;
                rd_next[11:9] = state_reg;
                rd_next[15:12] = combo_act_reg;
                rd_next[16] = ana_en_act_reg;
            end
            `OFS_APPLIED: begin
                rd_next[9:0] = FWD_TORQUE_LIMIT;
                rd_next[`APPLIED_REV_LSB +: 10] = REV_TORQUE_LIMIT;
            end
            default: begin
                if (HADDR[7:5] == 3'h2 && HADDR[1:0] == 2'h0) begin
                    rd_next[15:0] = speed_reg[HADDR[4:2]];
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            HRDATA <= 32'h0000_0000;
        end else if (bus_acc && !HWRITE) begin
            HRDATA <= rd_next;
        end
    end

    // Mode decode from combination and switch levels
    assign idx = {mode_sw_reg, fwd_sel_reg, rev_sel_reg};

    always_comb begin
        mode_raw = MD_POSITION;
        unique case (combo_act_reg)
            4'h4, 4'h5, 4'h6: begin
                if (idx != 3'h0) begin
                    mode_raw = MD_SPEED_CONTACT;
                end else if (combo_act_reg == 4'h4) begin
                    mode_raw = MD_SPEED_ANALOG;
                end else if (combo_act_reg == 4'h5) begin
                    mode_raw = MD_POSITION;
                end else begin
                    mode_raw = MD_TORQUE;
                end
            end
            4'h7: mode_raw = mode_sw_reg ? MD_SPEED_ANALOG : MD_POSITION;
            4'h8: mode_raw = mode_sw_reg ? MD_TORQUE : MD_POSITION;
            4'h9: mode_raw = mode_sw_reg ? MD_SPEED_ANALOG : MD_TORQUE;
            4'ha: mode_raw = mode_sw_reg ? MD_ZERO_CLAMP : MD_SPEED_ANALOG;
            4'hb: mode_raw = mode_sw_reg ? MD_POS_INHIBIT : MD_POSITION;
            default: mode_raw = MD_POSITION;
        endcase
    end

    // Speed to position switch waits for the motor to stop or the decel time to pass
    assign goal_pos = (combo_act_reg == 4'h5) && (mode_raw == MD_POSITION);
    assign decel_done = (decel_ms_reg >= decel_time_reg);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_SPEED: begin
                if (goal_pos) begin
                    state_next = (ACTIVE_MODE == MD_SPEED_CONTACT) ? ST_DECEL : ST_POS;
                end
            end
            ST_DECEL: begin
                if (!goal_pos) begin
                    state_next = ST_SPEED;
                end else if (MOTOR_STOPPED_INPUT || decel_done) begin
                    state_next = ST_POS;
                end
            end
            ST_POS: begin
                if (!goal_pos) begin
                    state_next = ST_SPEED;
                end
            end
            default: state_next = ST_SPEED;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_SPEED;
        end else begin
            state_reg <= state_next;
        end
    end

    // Millisecond count of the deceleration window
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ms_cnt_reg <= 17'h0_0000;
            decel_ms_reg <= 16'h0000;
        end else if (state_reg != ST_DECEL) begin
            ms_cnt_reg <= 17'h0_0000;
            decel_ms_reg <= 16'h0000;
        end else if (ms_cnt_reg == 17'(MS_CYCLES - 1)) begin
            ms_cnt_reg <= 17'h0_0000;
            if (!decel_done) begin
                decel_ms_reg <= decel_ms_reg + 16'h0001;
            end
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 17'h0_0001;
        end
    end

    // Mode actually applied
    always_comb begin
        mode_eff = mode_raw;
        if (goal_pos && (state_reg == ST_DECEL || state_next == ST_DECEL)) begin
            mode_eff = MD_DECEL;
        end
    end

    // Mode, speed and direction outputs
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ACTIVE_MODE <= MD_POSITION;
            SPEED_INDEX <= 3'h0;
            DIR_REVERSE <= 1'b0;
            SPEED_REF <= 16'h0000;
        end else begin
            ACTIVE_MODE <= mode_eff;
            if (contact_combo(combo_act_reg) && mode_eff == MD_SPEED_CONTACT) begin
                SPEED_INDEX <= idx;
                DIR_REVERSE <= mode_sw_reg;
                SPEED_REF <= speed_reg[idx];
            end else begin
                SPEED_INDEX <= 3'h0;
                DIR_REVERSE <= 1'b0;
                SPEED_REF <= 16'h0000;
            end
        end
    end

    // Limit source selection
    assign base_lim[0] = fwd_sel_reg ? fwd_ext_reg : fwd_int_reg;
    assign base_lim[1] = rev_sel_reg ? rev_ext_reg : rev_int_reg;

    // Analog limit magnitude, polarity ignored
    assign aref_abs = aref_reg[15] ? 16'(-aref_reg) : aref_reg;
    assign ana_lim = (aref_abs > 16'h03ff) ? 10'h3ff : aref_abs[9:0];
    assign ana_use = ana_en_act_reg && (mode_eff != MD_TORQUE);

    for (genvar d = 0; d < 2; d++) begin : g_dir
        limit_clamp u_clamp (
            .base_lim(base_lim[d]),
            .ana_lim(ana_lim),
            .ana_use(ana_use),
            .motor_max(motor_max_reg),
            .lim_out(lim_next[d])
        );
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            FWD_TORQUE_LIMIT <= `RST_INT_LIM;
            REV_TORQUE_LIMIT <= `RST_INT_LIM;
        end else begin
            FWD_TORQUE_LIMIT <= lim_next[0];
            REV_TORQUE_LIMIT <= lim_next[1];
        end
    end

    // Torque limited indication
    assign tdem_mag = tdem_reg[15] ? 17'(-{tdem_reg[15], tdem_reg}) : {1'b0, tdem_reg};

    always_comb begin
        if (tdem_reg[15]) begin
            tlim_next = tdem_mag > {7'h00, REV_TORQUE_LIMIT};
        end else begin
            tlim_next = tdem_mag > {7'h00, FWD_TORQUE_LIMIT};
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            TORQUE_LIMITED_FLAG <= 1'b0;
        end else begin
            TORQUE_LIMITED_FLAG <= tlim_next;
        end
    end

endmodule

//--- test/servo_sel_monitor.sv
// Checker of the selection and torque limit outputs, bound to the block
`timescale 1ns/100ps
module servo_sel_monitor
    import servo_sel_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Watched inputs
    input wire logic [1:0] HTRANS,
    input wire logic MODE_SWITCH_INPUT,
    input wire logic FWD_LIMIT_SELECT_INPUT,
    input wire logic REV_LIMIT_SELECT_INPUT,
    input wire logic [15:0] ANALOG_TORQUE_REF_INPUT,
    input wire logic [15:0] TORQUE_DEMAND_INPUT,
    input wire logic MOTOR_STOPPED_INPUT,
    // Watched outputs
    input wire logic [2:0] ACTIVE_MODE,
    input wire logic [2:0] SPEED_INDEX,
    input wire logic DIR_REVERSE,
    input wire logic [15:0] SPEED_REF,
    input wire logic [9:0] FWD_TORQUE_LIMIT,
    input wire logic [9:0] REV_TORQUE_LIMIT,
    input wire logic TORQUE_LIMITED_FLAG
);
    logic [2:0] sel;
    logic [15:0] mag;
    logic [15:0] lim;
    assign sel = {MODE_SWITCH_INPUT, FWD_LIMIT_SELECT_INPUT, REV_LIMIT_SELECT_INPUT};
    assign mag = TORQUE_DEMAND_INPUT[15] ? 16'h0 - TORQUE_DEMAND_INPUT : TORQUE_DEMAND_INPUT;
    assign lim = TORQUE_DEMAND_INPUT[15] ? {6'h0, REV_TORQUE_LIMIT} : {6'h0, FWD_TORQUE_LIMIT};
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);
    AST_DIR: assert property (ACTIVE_MODE == MD_SPEED_CONTACT |->
        DIR_REVERSE == SPEED_INDEX[2] && SPEED_INDEX != 3'h0) else $error("dir");
    AST_IDLE_OUT: assert property (ACTIVE_MODE != MD_SPEED_CONTACT |->
        SPEED_INDEX == 3'h0 && !DIR_REVERSE && SPEED_REF == 16'h0) else $error("idle");
    AST_IDX_PAIR: assert property ($stable(sel) [*3] ##0 ACTIVE_MODE == MD_SPEED_CONTACT
        |-> SPEED_INDEX == sel) else $error("index");
    AST_LIM_RANGE: assert property (FWD_TORQUE_LIMIT <= 10'h190 &&
        REV_TORQUE_LIMIT <= 10'h190) else $error("range");
    AST_FLAG: assert property (
        $stable({TORQUE_DEMAND_INPUT, FWD_TORQUE_LIMIT, REV_TORQUE_LIMIT}) [*3]
        |-> TORQUE_LIMITED_FLAG == (mag > lim)) else $error("flag");
    AST_DECEL_FROM: assert property ($rose(ACTIVE_MODE == MD_DECEL) |->
        $past(ACTIVE_MODE) == MD_SPEED_CONTACT) else $error("decel entry");
    AST_DECEL_EXIT: assert property (
        (ACTIVE_MODE == MD_DECEL && MOTOR_STOPPED_INPUT && sel == 3'h0)
        ##1 (MOTOR_STOPPED_INPUT && sel == 3'h0) [*2]
        |-> ##[0:1] ACTIVE_MODE == MD_POSITION) else $error("decel exit");
    AST_LIM_STABLE: assert property ((!HTRANS[1] && $stable(ACTIVE_MODE) &&
        $stable({sel, ANALOG_TORQUE_REF_INPUT})) [*8]
        |-> $stable(FWD_TORQUE_LIMIT) && $stable(REV_TORQUE_LIMIT)) else $error("limit");
endmodule

bind servo_mode_torque_limit_select servo_sel_monitor u_mon (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .HTRANS(HTRANS),
    .MODE_SWITCH_INPUT(MODE_SWITCH_INPUT), .FWD_LIMIT_SELECT_INPUT(FWD_LIMIT_SELECT_INPUT),
    .REV_LIMIT_SELECT_INPUT(REV_LIMIT_SELECT_INPUT),
    .ANALOG_TORQUE_REF_INPUT(ANALOG_TORQUE_REF_INPUT),
    .TORQUE_DEMAND_INPUT(TORQUE_DEMAND_INPUT), .MOTOR_STOPPED_INPUT(MOTOR_STOPPED_INPUT),
    .ACTIVE_MODE(ACTIVE_MODE), .SPEED_INDEX(SPEED_INDEX), .DIR_REVERSE(DIR_REVERSE),
    .SPEED_REF(SPEED_REF), .FWD_TORQUE_LIMIT(FWD_TORQUE_LIMIT),
    .REV_TORQUE_LIMIT(REV_TORQUE_LIMIT), .TORQUE_LIMITED_FLAG(TORQUE_LIMITED_FLAG)
);

//--- test/host_select_model.sv
// Host controller model driving the mode switch and limit select levels
`timescale 1ns/100ps
module host_select_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Command: switch, forward select, reverse select
    input wire logic [2:0] cmd,
    // Levels towards the drive
    output logic mode_switch,
    output logic fwd_select,
    output logic rev_select
);
    // Levels change just after an edge and hold until the next command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_switch <= 1'b0;
            fwd_select <= 1'b0;
            rev_select <= 1'b0;
        end else begin
            mode_switch <= cmd[2];
            fwd_select <= cmd[1];
            rev_select <= cmd[0];
        end
    end
endmodule

//--- test/tb_servo_mode_torque_limit_select.sv
// Self-checking bench of the mode and torque limit selection block
`timescale 1ns/100ps
`include "servo_sel_defines.svh"
module tb_servo_mode_torque_limit_select;
    import servo_sel_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [2:0] cmd = 3'h0;
    logic sw;
    logic fsel;
    logic rsel;
    logic [15:0] ana = 16'h0;
    logic [15:0] dem = 16'h0;
    logic stopped = 1'b0;
    logic [2:0] mode;
    logic [2:0] idx;
    logic dir;
    logic [15:0] sref;
    logic [9:0] flim;
    logic [9:0] rlim;
    logic tflag;
    int fails = 0;
    int n_tests = 0;
    logic [3:0] combos [7] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
    mode_t m_off [7] = '{MD_SPEED_ANALOG, MD_TORQUE, MD_POSITION, MD_POSITION, MD_TORQUE,
        MD_SPEED_ANALOG, MD_POSITION};
    mode_t m_on [7] = '{MD_SPEED_CONTACT, MD_SPEED_CONTACT, MD_SPEED_ANALOG, MD_TORQUE,
        MD_SPEED_ANALOG, MD_ZERO_CLAMP, MD_POS_INHIBIT};
    logic [7:0] ra [9] = '{`OFS_CTRL, `OFS_FWD_INT, `OFS_REV_INT, `OFS_FWD_EXT, `OFS_REV_EXT,
        `OFS_MOTOR_MAX, `OFS_DECEL, 8'h30, `OFS_SPEED_BASE};
    logic [31:0] rv [9] = '{{27'h0, `RST_ANA_EN, `RST_COMBO}, {22'h0, `RST_INT_LIM},
        {22'h0, `RST_INT_LIM}, {22'h0, `RST_EXT_LIM}, {22'h0, `RST_EXT_LIM},
        {22'h0, `RST_MOTOR_MAX}, {16'h0, `RST_DECEL_MS}, 32'h0, 32'h0};

    always #5 clk = ~clk;

    host_select_model host (.clk(clk), .rst_n(rst_n), .cmd(cmd), .mode_switch(sw),
        .fwd_select(fsel), .rev_select(rsel));

    servo_mode_torque_limit_select #(.MS_CYCLES(10)) uut (.CORE_CLK(clk), .RST_N(rst_n),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .MODE_SWITCH_INPUT(sw), .FWD_LIMIT_SELECT_INPUT(fsel),
        .REV_LIMIT_SELECT_INPUT(rsel), .ANALOG_TORQUE_REF_INPUT(ana),
        .TORQUE_DEMAND_INPUT(dem), .MOTOR_STOPPED_INPUT(stopped), .ACTIVE_MODE(mode),
        .SPEED_INDEX(idx), .DIR_REVERSE(dir), .SPEED_REF(sref), .FWD_TORQUE_LIMIT(flim),
        .REV_TORQUE_LIMIT(rlim), .TORQUE_LIMITED_FLAG(tflag));

    task automatic stop_test();
        if (fails == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_ready();
        int k;
        k = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            k++;
            if (k > 20) begin
                fails++;
                stop_test();
            end
            @(posedge clk);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check($sformatf("reg %h", a), exp, x);
        check("resp", 32'h0, hresp);
    endtask

    task automatic settle();
        repeat (6) @(posedge clk);
    endtask

    task automatic sel(input logic [2:0] c);
        @(posedge clk);
        cmd <= c;
        settle();
    endtask

    task automatic lims(input logic [9:0] f, input logic [9:0] r);
        check("fwd limit", f, flim);
        check("rev limit", r, rlim);
    endtask

    task automatic flag_chk(input logic [15:0] d, input logic exp);
        @(posedge clk);
        dem <= d;
        settle();
        check("limited flag", exp, tflag);
    endtask

    task automatic stop_lvl(input logic v);
        @(posedge clk);
        stopped <= v;
        settle();
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rd(ra[i], rv[i]);
        end
        wr(`OFS_FWD_EXT, 32'h3ff);
        rd(`OFS_FWD_EXT, {22'h0, `MAX_EXT_LIM});
        wr(`OFS_FWD_INT, 32'h3ff);
        rd(`OFS_FWD_INT, {22'h0, `MAX_INT_LIM});
        wr(`OFS_FWD_INT, 32'hc8);
        wr(`OFS_REV_INT, 32'h96);
        wr(`OFS_FWD_EXT, 32'h32);
        wr(`OFS_REV_EXT, 32'h50);
        sel(3'b000);
        lims(10'hc8, 10'h96);
        sel(3'b010);
        lims(10'h32, 10'h96);
        sel(3'b001);
        lims(10'hc8, 10'h50);
        flag_chk(16'hffaf, 1'b1);
        flag_chk(16'hffb0, 1'b0);
        flag_chk(16'h00c9, 1'b1);
        flag_chk(16'h00c8, 1'b0);
        wr(`OFS_MOTOR_MAX, 32'h78);
        settle();
        lims(10'h78, 10'h50);
        wr(`OFS_MOTOR_MAX, 32'h12c);
        @(posedge clk);
        ana <= 16'hffba;
        wr(`OFS_CTRL, 32'h15);
        settle();
        lims(10'hc8, 10'h50);
        wr(`OFS_CTRL, 32'h115);
        settle();
        lims(10'h46, 10'h46);
        wr(`OFS_CTRL, 32'h116);
        sel(3'b000);
        check("mode", MD_TORQUE, mode);
        lims(10'hc8, 10'h96);
        for (int i = 0; i < 7; i++) begin
            wr(`OFS_CTRL, {24'h1, 4'h0, combos[i]});
            sel(3'b000);
            check("mode off", m_off[i], mode);
            sel(3'b100);
            check("mode on", m_on[i], mode);
        end
        wr(`OFS_CTRL, 32'h105);
        for (int i = 1; i < 8; i++) begin
            wr(`OFS_SPEED_BASE + 8'(4 * i), 32'h100 + i);
        end
        for (int i = 1; i < 8; i++) begin
            sel(3'(i));
            check("mode", MD_SPEED_CONTACT, mode);
            check("index", 32'(i), idx);
            check("dir", (i > 3), dir);
            check("speed", 32'h100 + i, sref);
        end
        sel(3'b000);
        check("mode", MD_DECEL, mode);
        check("speed", 32'h0, sref);
        stop_lvl(1'b1);
        check("mode", MD_POSITION, mode);
        stop_lvl(1'b0);
        wr(`OFS_DECEL, 32'h2);
        sel(3'b001);
        sel(3'b000);
        check("mode", MD_DECEL, mode);
        repeat (25) @(posedge clk);
        check("mode", MD_POSITION, mode);
        stop_test();
    end
endmodule
